// ==== rtl/arsr_top.sv ====
// Result, alert status and configuration registers of the converter
// How it works
// - Normal mode: each result read starts a conversion that replaces it.
// - Result bits 11:0 straight binary, MSB bit 11; bits 14:12 read zero.
// - Result register at pointer 0, read-only, resets to zero.
// - With alert bit enable on, result bit 15 reads one if any flag set.
// - Result bit 15 reads zero when enable off or no flag set.
// - Status register at pointer 1, readable and writable, resets to zero.
// - Both status flags are active high: one means limit crossed.
// - Status bits 7:2 read zero; the controller writes zeros there.
// - Over-range flag sets when a result exceeds the high limit.
// - Over flag self-clears on a result below high limit minus margin.
// - Under-range flag sets when a result is below the low limit.
// - Under flag self-clears on a result above low limit plus margin.
// - Writing one to a flag bit clears that flag.
// - Margin-based self-clearing happens only while alert hold is off.
// - With alert hold on, a set flag stays until the controller clears it.
// - Configuration register at pointer 2, readable and writable.
// - Only the three low pointer bits select a register.
// - Hold off: flags self-clear once back inside limits by the margin.
// - Nonzero interval field selects automatic periodic conversions.
`timescale 1ns/1ps
`default_nettype none
`include "arsr_regs.svh"
module arsr_top #(
  parameter int unsigned CONV_BASE_CYCLES = `ARSR_CONV_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Register access port
  input wire logic [7:0] reg_ptr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Converter core
  output logic conv_start_out,
  input wire logic conv_done_in,
  input wire logic [11:0] conv_data_in,
  // Limit values from the limit registers
  input wire logic [11:0] high_limit_in,
  input wire logic [11:0] low_limit_in,
  input wire logic [11:0] threshold_margin_in,
  // Status toward the alert pin logic
  output logic [1:0] alert_status_out,
  output logic alert_flag_out,
  output logic [7:0] config_out
);

  ////////////////////////////////////////////////////////////////////////
  // State

  localparam arsr_pkg::arsr_top_state_t RST = '{
    result: `ARSR_RESULT_RST,
    over: 1'b0,
    under: 1'b0,
    cfg: `ARSR_CONFIG_RST,
    rdata: 16'h0000,
    rvalid: 1'b0,
    alert_flag: 1'b0};

  arsr_pkg::arsr_top_state_t s;
  arsr_pkg::arsr_top_state_t next_s;

  logic [`ARSR_PTR_BITS-1:0] ptr;
  logic [1:0] w1c;
  logic [12:0] ext_data;
  logic [12:0] high_minus;
  logic [12:0] low_plus;

  arsr_conv_if conv_link ();

  ////////////////////////////////////////////////////////////////////////
  // Read decode

  function automatic logic [15:0] read_word(
    input logic [`ARSR_PTR_BITS-1:0] sel,
    input arsr_pkg::arsr_top_state_t st);
    logic [15:0] w;
    w = 16'h0000;
    unique case (sel)
      `ARSR_PTR_RESULT:
      begin
        w[`ARSR_RES_MSB:0] = st.result;
        w[`ARSR_RES_ALERT] = st.cfg[`ARSR_CFG_FLAG_EN]
          & (st.over | st.under);
      end
      `ARSR_PTR_STATUS:
      begin
        w[`ARSR_ST_OVER] = st.over;
        w[`ARSR_ST_UNDER] = st.under;
      end
      `ARSR_PTR_CONFIG:
      begin
        w[7:0] = st.cfg;
      end
      default:
      begin
        w = 16'h0000;
      end
    endcase
    read_word = w;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Sequencer link

  assign ptr = reg_ptr_in[`ARSR_PTR_BITS-1:0];
  assign conv_link.read_trig = reg_rd_in && (ptr == `ARSR_PTR_RESULT);
  assign conv_link.cycle_code =
    s.cfg[`ARSR_CFG_CYC_MSB:`ARSR_CFG_CYC_LSB];
  assign conv_link.conv_done = conv_done_in;

  arsr_conv_seq #(
    .CONV_BASE_CYCLES(CONV_BASE_CYCLES)
  ) u_seq (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .link(conv_link.seq)
  );

  ////////////////////////////////////////////////////////////////////////
  // Limit arithmetic, widened so the sum never wraps and bit 12 flags a negative difference

  assign ext_data = {1'b0, conv_data_in};
  assign high_minus = {1'b0, high_limit_in} - {1'b0, threshold_margin_in};
  assign low_plus = {1'b0, low_limit_in} + {1'b0, threshold_margin_in};

  assign w1c = (reg_wr_in && ptr == `ARSR_PTR_STATUS) ?
    reg_wdata_in[1:0] : 2'h0;

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    next_s = s;
    next_s.rvalid = 1'b0;
    if (reg_rd_in)
    begin
      next_s.rdata = read_word(ptr, s);
      next_s.rvalid = 1'b1;
    end
    if (reg_wr_in && ptr == `ARSR_PTR_CONFIG)
    begin
      next_s.cfg = reg_wdata_in & `ARSR_CFG_WMASK;
    end
    // Clear by writing one; a same-cycle set below wins
    if (w1c[`ARSR_ST_OVER])
    begin
      next_s.over = 1'b0;
    end
    if (w1c[`ARSR_ST_UNDER])
    begin
      next_s.under = 1'b0;
    end
    if (conv_done_in)
    begin
      next_s.result = conv_data_in;
      if (conv_data_in > high_limit_in)
      begin
        next_s.over = 1'b1;
      end
      else if (!s.cfg[`ARSR_CFG_HOLD] && ext_data < high_minus
               && !high_minus[12])
      begin
        next_s.over = 1'b0;
      end
      if (conv_data_in < low_limit_in)
      begin
        next_s.under = 1'b1;
      end
      else if (!s.cfg[`ARSR_CFG_HOLD] && ext_data > low_plus)
      begin
        next_s.under = 1'b0;
      end
    end
    next_s.alert_flag = next_s.cfg[`ARSR_CFG_FLAG_EN]
      & (next_s.over | next_s.under);
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s <= RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata_out = s.rdata;
  assign reg_rvalid_out = s.rvalid;
  assign conv_start_out = conv_link.start;
  assign alert_status_out = {s.over, s.under};
  assign alert_flag_out = s.alert_flag;
  assign config_out = s.cfg;

endmodule
`default_nettype wire

// ==== rtl/arsr_regs.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef ARSR_REGS_SVH
`define ARSR_REGS_SVH

// Pointer values (low three pointer bits)
`define ARSR_PTR_BITS 3
`define ARSR_PTR_RESULT 3'h0
`define ARSR_PTR_STATUS 3'h1
`define ARSR_PTR_CONFIG 3'h2

// Reset values
`define ARSR_RESULT_RST 12'h000
`define ARSR_STATUS_RST 2'h0
`define ARSR_CONFIG_RST 8'h00

// Result word fields
`define ARSR_RES_ALERT 15
`define ARSR_RES_MSB 11

// Status fields
`define ARSR_ST_OVER 1
`define ARSR_ST_UNDER 0

// Configuration fields
`define ARSR_CFG_CYC_MSB 7
`define ARSR_CFG_CYC_LSB 5
`define ARSR_CFG_HOLD 4
`define ARSR_CFG_FLAG_EN 3
`define ARSR_CFG_WMASK 8'hFD

// Timing: one conversion time is the base of the automatic interval
`define ARSR_CLK_PERIOD_NS 10
`define ARSR_CONV_TIME_NS 1000
`define ARSR_CONV_CYCLES \
  ((`ARSR_CONV_TIME_NS + `ARSR_CLK_PERIOD_NS - 1) / `ARSR_CLK_PERIOD_NS)
// Interval code 1 gives 32 conversion times, each step doubles it
`define ARSR_AUTO_SHIFT_BASE 5'h04

`endif

// ==== rtl/arsr_pkg.sv ====
// Types shared by the result and alert status register block
package arsr_pkg;

  typedef enum logic {ARSR_IDLE, ARSR_BUSY} arsr_phase_t;

  typedef struct packed {
    arsr_phase_t phase;
    logic pending;
    logic start;
    logic [31:0] timer;
  } arsr_seq_state_t;

  typedef struct packed {
    logic [11:0] result;
    logic over;
    logic under;
    logic [7:0] cfg;
    logic [15:0] rdata;
    logic rvalid;
    logic alert_flag;
  } arsr_top_state_t;

endpackage

// ==== rtl/arsr_conv_if.sv ====
// Link between the register block and its conversion sequencer
`timescale 1ns/1ps
`default_nettype none
interface arsr_conv_if;
  logic read_trig;
  logic [2:0] cycle_code;
  logic conv_done;
  logic start;

  modport seq (input read_trig, input cycle_code, input conv_done,
               output start);
  modport ctl (output read_trig, output cycle_code, output conv_done,
               input start);
endinterface
`default_nettype wire

// ==== rtl/arsr_conv_seq.sv ====
// Conversion sequencer: read-triggered or interval-timed conversion starts
`timescale 1ns/1ps
`default_nettype none
`include "arsr_regs.svh"
module arsr_conv_seq #(
  parameter int unsigned CONV_BASE_CYCLES = `ARSR_CONV_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Control link
  arsr_conv_if.seq link
);

  generate
    if (CONV_BASE_CYCLES < 1 || CONV_BASE_CYCLES > 32'h0000_FFFF)
    begin : g_bad
      $error("CONV_BASE_CYCLES out of range");
    end
  endgenerate

  localparam arsr_pkg::arsr_seq_state_t RST = '{
    phase: arsr_pkg::ARSR_IDLE, pending: 1'b0, start: 1'b0,
    timer: 32'h0000_0000};

  arsr_pkg::arsr_seq_state_t s;
  arsr_pkg::arsr_seq_state_t next_s;

  function automatic logic [31:0] interval_len(input logic [2:0] code);
    logic [31:0] base;
    base = 32'(CONV_BASE_CYCLES);
    interval_len = base << (5'(code) + `ARSR_AUTO_SHIFT_BASE);
  endfunction

  assign link.start = s.start;

  always_comb
  begin
    next_s = s;
    next_s.start = 1'b0;
    if (link.cycle_code == 3'h0)
    begin
      next_s.timer = 32'h0000_0000;
      if (link.read_trig)
      begin
        next_s.pending = 1'b1;
      end
    end
    else if (s.timer >= interval_len(link.cycle_code) - 32'h0000_0001)
    begin
      next_s.timer = 32'h0000_0000;
      next_s.pending = 1'b1;
    end
    else
    begin
      next_s.timer = s.timer + 32'h0000_0001;
    end
    unique case (s.phase)
      arsr_pkg::ARSR_IDLE:
      begin
        if (next_s.pending)
        begin
          next_s.start = 1'b1;
          next_s.pending = 1'b0;
          next_s.phase = arsr_pkg::ARSR_BUSY;
        end
      end
      arsr_pkg::ARSR_BUSY:
      begin
        if (link.conv_done)
        begin
          next_s.phase = arsr_pkg::ARSR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s <= RST;
    end
    else
    begin
      s <= next_s;
    end
  end

endmodule
`default_nettype wire

// ==== tb/arsr_conv_model.sv ====
// Behavioural converter core answering each start with one result
`timescale 1ns/1ps
`default_nettype none
module arsr_conv_model (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Start request, value and latency
  input wire logic start_in,
  input wire logic [11:0] value_in,
  input wire logic [3:0] lat_in,
  // Result toward the block
  output logic done_out,
  output logic [11:0] data_out
);
  logic [3:0] cnt;
  // Data is valid only with done; otherwise it shows the inverse
  assign data_out = done_out ? value_in : ~value_in;
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt <= 4'h0;
      done_out <= 1'b0;
    end
    else
    begin
      done_out <= (cnt == 4'h1);
      if (start_in)
        cnt <= lat_in;
      else if (cnt != 4'h0)
        cnt <= cnt - 4'h1;
    end
  end
endmodule
`default_nettype wire

// ==== tb/arsr_top_chk.sv ====
// Concurrent checks on the register block ports
`timescale 1ns/1ps
`default_nettype none
module arsr_top_chk (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Register access port
  input wire logic [7:0] reg_ptr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_rdata_out,
  // Converter core and limits
  input wire logic conv_start_out,
  input wire logic conv_done_in,
  input wire logic [11:0] conv_data_in,
  input wire logic [11:0] high_limit_in,
  input wire logic [11:0] low_limit_in,
  input wire logic [11:0] threshold_margin_in,
  // Status
  input wire logic [1:0] alert_status_out,
  input wire logic alert_flag_out,
  input wire logic [7:0] config_out
);
  logic busy;
  logic [12:0] low_up;
  assign low_up = {1'b0, low_limit_in} + {1'b0, threshold_margin_in};
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      busy <= 1'b0;
    else if (conv_start_out)
      busy <= 1'b1;
    else if (conv_done_in)
      busy <= 1'b0;
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  sequence rd_res;
    reg_rd_in && reg_ptr_in[2:0] == 3'h0;
  endsequence
  sequence start_pulse;
    conv_start_out;
  endsequence
  AST_START: assert property (rd_res ##0 (config_out[7:5] == 3'h0
    && !busy && !conv_start_out) |=> start_pulse) else $error("no start");
  AST_FLAG: assert property (alert_flag_out
    == (config_out[3] && |alert_status_out)) else $error("bad alert flag");
  AST_RES_FMT: assert property (rd_res |=> reg_rdata_out[14:12] == 3'h0
    && reg_rdata_out[15] == $past(config_out[3] && |alert_status_out))
    else $error("bad result word");
  AST_STAT_RD: assert property (reg_rd_in && reg_ptr_in[2:0] == 3'h1 |=>
    reg_rdata_out == {14'h0000, $past(alert_status_out)})
    else $error("bad status read");
  AST_CFG_WR: assert property (reg_wr_in && reg_ptr_in[2:0] == 3'h2 |=>
    config_out == ($past(reg_wdata_in) & 8'hfd)) else $error("bad config");
  AST_OVER_SET: assert property (conv_done_in
    && conv_data_in > high_limit_in |=> alert_status_out[1])
    else $error("over not set");
  AST_UNDER_SET: assert property (conv_done_in
    && conv_data_in < low_limit_in |=> alert_status_out[0])
    else $error("under not set");
  AST_OVER_CLR: assert property (conv_done_in && !config_out[4]
    && high_limit_in >= threshold_margin_in
    && conv_data_in < high_limit_in - threshold_margin_in
    |=> !alert_status_out[1]) else $error("over kept");
  AST_UNDER_CLR: assert property (conv_done_in && !config_out[4]
    && {1'b0, conv_data_in} > low_up |=> !alert_status_out[0])
    else $error("under kept");
  AST_HOLD: assert property (config_out[4] && alert_status_out[1]
    && !(reg_wr_in && reg_ptr_in[2:0] == 3'h1 && reg_wdata_in[1])
    |=> alert_status_out[1]) else $error("held flag lost");
  AST_W1C: assert property (reg_wr_in && reg_ptr_in[2:0] == 3'h1
    && reg_wdata_in[0] && !(conv_done_in && conv_data_in < low_limit_in)
    |=> !alert_status_out[0]) else $error("flag not cleared");
endmodule
bind arsr_top arsr_top_chk arsr_top_chk_i (.*);
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the result and alert status registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] reg_ptr_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_rd_in = 1'b0;
  logic [15:0] reg_rdata_out;
  logic reg_rvalid_out, conv_start_out, conv_done_in, alert_flag_out;
  logic [11:0] conv_data_in;
  logic [11:0] high_limit_in = 12'h800;
  logic [11:0] low_limit_in = 12'h100;
  logic [11:0] threshold_margin_in = 12'h010;
  logic [1:0] alert_status_out;
  logic [7:0] config_out;
  logic [11:0] val = 12'h000;
  logic [3:0] lat = 4'h3;
  logic [15:0] d;
  int miscompares = 0;
  int checks_done = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  arsr_top #(.CONV_BASE_CYCLES(1)) arsr_top_i (.*);
  arsr_conv_model arsr_conv_model_i (.sys_clk_in, .rst_in,
    .start_in(conv_start_out), .value_in(val), .lat_in(lat),
    .done_out(conv_done_in), .data_out(conv_data_in));
  //////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (miscompares == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", name, exp, seen);
      miscompares++;
    end
  endtask
  task automatic tick();
    @(posedge sys_clk_in);
    #1;
  endtask
  task automatic fail();
    miscompares++;
  endtask
  task automatic wr(logic [7:0] p, logic [7:0] v);
    reg_ptr_in = p;
    reg_wdata_in = v;
    reg_wr_in = 1'b1;
    tick();
    reg_wr_in = 1'b0;
    tick();
  endtask
  task automatic rd(logic [7:0] p);
    reg_ptr_in = p;
    reg_rd_in = 1'b1;
    tick();
    reg_rd_in = 1'b0;
    for (int i = 0; i < 20 && reg_rvalid_out !== 1'b1; i++)
      tick();
    if (reg_rvalid_out !== 1'b1)
      fail();
    d = reg_rdata_out;
    tick();
  endtask
  task automatic wdone();
    for (int i = 0; i < 100 && conv_done_in !== 1'b1; i++)
      tick();
    if (conv_done_in !== 1'b1)
      fail();
    tick();
  endtask
  task automatic conv(logic [11:0] v);
    val = v;
    rd(8'h00);
    wdone();
  endtask
  task automatic res(logic [15:0] exp);
    rd(8'h00);
    chk("result", d, exp);
    wdone();
  endtask
  task automatic st(logic [1:0] exp);
    rd(8'h01);
    chk("status", d, {14'h0000, exp});
  endtask
  initial
  begin
    repeat (20) @(posedge sys_clk_in);
    #1;
    rst_in = 1'b0;
    tick();
    st(2'h0);
    rd(8'h02);
    chk("config", d, 16'h0000);
    rd(8'h05);
    chk("unused", d, 16'h0000);
    res(16'h0000);
    wr(8'h00, 8'hff);
    st(2'h1);
    res(16'h0000);
    wr(8'h01, 8'h01);
    st(2'h0);
    wr(8'h02, 8'h0a);
    rd(8'h02);
    chk("config", d, 16'h0008);
    lat = 4'h9;
    conv(12'h900);
    res(16'h8900);
    chk("alert flag", {15'h0000, alert_flag_out}, 16'h0001);
    st(2'h2);
    conv(12'h7f0);
    st(2'h2);
    conv(12'h7ef);
    st(2'h0);
    res(16'h07ef);
    conv(12'h0ff);
    st(2'h1);
    conv(12'h110);
    st(2'h1);
    conv(12'h111);
    st(2'h0);
    wr(8'h02, 8'h18);
    conv(12'h801);
    st(2'h2);
    conv(12'h400);
    st(2'h2);
    wr(8'h01, 8'h02);
    st(2'h0);
    chk("alert flag", {15'h0000, alert_flag_out}, 16'h0000);
    wr(8'h02, 8'h20);
    wdone();
    summarize();
  end
endmodule
`default_nettype wire
